// >>> hw/dual_timer.v
// Timer 0/1 mode, gating, clock select and count registers, plus the
// Timer 2 clock-enable selection.
// Assumes a one-cycle register write strobe and combinational-free reads
// on the core's register port; run bits and polarity come from elsewhere.
//
// What this block does
// (RQ1) Ungated Timer 1 runs whenever its run bit set
// (RQ2) Gated Timer 1 needs run and active input
// (RQ3) Timer 1 counts clock or count-pin falling edges
// (RQ4) Timer 1 modes: 13-bit, 16-bit, reload, inactive
// (RQ5) Timer 0 gating by run bit and input
// (RQ6) Timer 0 counts clock or count-pin falling edges
// (RQ7) Timer 0 modes: 13-bit, 16-bit, reload, split
// (RQ8) Timer 1 clock: prescaled or system clock
// (RQ9) Timer 0 clock: prescaled or system clock
// (RQ10) Prescaler: divide 12, 4, 48, ext/8
// (RQ11) External clock/8 synchronised; ext not faster
// (RQ12) Timer 2 high byte clock in split mode
// (RQ13) Timer 2 low byte clock select
// (RQ14) Clock select bits 7, 2 read zero
// (RQ15) Timer 0 low and high bytes accessible
// (RQ16) Timer 1 low byte accessible
// (RQ17) 13-bit mode overflow from 0x1FFF sets flag
// (RQ18) Reload mode reloads low from high byte
// (RQ19) Split high byte runs on timer1_run, flag 1
// (RQ20) Timer 1 high byte accessible
// (RQ21) Count pins synchronised, one increment per edge
`timescale 1ns/1ps
`include "timer_consts.vh"
module dual_timer #(
   parameter DIV12_COUNT = `DIV_12,
   parameter DIV4_COUNT  = `DIV_4,
   parameter DIV48_COUNT = `DIV_48,
   parameter EXT_COUNT   = `DIV_EXT
) (
   // Clock and reset
   input  wire       ref_clk_in,
   input  wire       rst_b_in,
   // Register port
   input  wire [7:0] reg_addr_in,
   input  wire [7:0] reg_wdata_in,
   input  wire       reg_write_in,
   output reg  [7:0] reg_rdata_out,
   // Run, polarity and Timer 2 controls
   input  wire       timer0_run_in,
   input  wire       timer1_run_in,
   input  wire       input0_polarity_in,
   input  wire       input1_polarity_in,
   input  wire       timer2_split_in,
   input  wire       timer2_ext_clk_select_in,
   // Pins
   input  wire       ext_input0_in,
   input  wire       ext_input1_in,
   input  wire       timer0_count_pin_in,
   input  wire       timer1_count_pin_in,
   input  wire       ext_clk_in,
   // Overflow events
   output reg        timer0_overflow_out,
   output reg        timer1_overflow_out,
   // Timer 2 count enables
   output reg        timer2_low_tick_out,
   output reg        timer2_high_tick_out
);
   // ==========================================
   // Registers
   reg  [7:0] timer_mode_reg;
   reg  [7:0] clock_select_reg;
   reg  [7:0] timer0_low_byte;
   reg  [7:0] timer0_high_byte;
   reg  [7:0] timer1_low_byte;
   reg  [7:0] timer1_high_byte;
   reg  [5:0] div12_cnt;
   reg  [5:0] div4_cnt;
   reg  [5:0] div48_cnt;
   reg  [3:0] ext_cnt;
   reg        div12_tick;
   reg        div4_tick;
   reg        div48_tick;
   reg        ext8_tick;
   reg        pre_tick;
   reg  [7:0] next_t0_low;
   reg  [7:0] next_t0_high;
   reg  [7:0] next_t1_low;
   reg  [7:0] next_t1_high;
   reg        next_ovf0;
   reg        next_ovf1;
   reg        t2_ext_tick;

   wire       in0_level;
   wire       in1_level;
   wire       cnt0_fall;
   wire       cnt1_fall;
   wire       ext_rise;
   wire [1:0] mode0 = timer_mode_reg[`MODE_T0_HI:`MODE_T0_LO];
   wire [1:0] mode1 = timer_mode_reg[`MODE_T1_HI:`MODE_T1_LO];

   // ==========================================
   // Pin synchronisers
   pin_edge_sync u_in0 (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .pin_in(ext_input0_in), .level_out(in0_level), .fall_out(),
      .rise_out());
   pin_edge_sync u_in1 (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .pin_in(ext_input1_in), .level_out(in1_level), .fall_out(),
      .rise_out());
   pin_edge_sync u_cnt0 (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .pin_in(timer0_count_pin_in), .level_out(), .fall_out(cnt0_fall),
      .rise_out()); // [RQ21]
   pin_edge_sync u_cnt1 (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .pin_in(timer1_count_pin_in), .level_out(), .fall_out(cnt1_fall),
      .rise_out()); // [RQ21]
   pin_edge_sync u_ext (.ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .pin_in(ext_clk_in), .level_out(), .fall_out(),
      .rise_out(ext_rise)); // [RQ11]

   // ==========================================
   // Functions
   function gate_ok;
      input run;
      input qualify;
      input level;
      input polarity;
      begin
         gate_ok = run & (~qualify | (level == polarity)); // [RQ1] [RQ2]
      end
   endfunction

   function clk_tick;
      input source;
      input sel;
      input pin_fall;
      input pre;
      begin
         if (source)
            clk_tick = pin_fall; // [RQ3] [RQ6]
         else if (sel)
            clk_tick = 1'b1; // [RQ8] [RQ9]
         else
            clk_tick = pre;
      end
   endfunction

   // ==========================================
   // Prescaler
   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         div12_cnt  <= 6'h00;
         div4_cnt   <= 6'h00;
         div48_cnt  <= 6'h00;
         ext_cnt    <= 4'h0;
         div12_tick <= 1'b0;
         div4_tick  <= 1'b0;
         div48_tick <= 1'b0;
         ext8_tick  <= 1'b0;
      end else begin
         div12_tick <= (div12_cnt == DIV12_COUNT - 1);
         div12_cnt  <= (div12_cnt == DIV12_COUNT - 1) ? 6'h00
                       : div12_cnt + 6'h01; // [RQ10]
         div4_tick  <= (div4_cnt == DIV4_COUNT - 1);
         div4_cnt   <= (div4_cnt == DIV4_COUNT - 1) ? 6'h00
                       : div4_cnt + 6'h01; // [RQ10]
         div48_tick <= (div48_cnt == DIV48_COUNT - 1);
         div48_cnt  <= (div48_cnt == DIV48_COUNT - 1) ? 6'h00
                       : div48_cnt + 6'h01; // [RQ10]
         ext8_tick  <= 1'b0;
         if (ext_rise) begin
            ext8_tick <= (ext_cnt == EXT_COUNT - 1);
            ext_cnt   <= (ext_cnt == EXT_COUNT - 1) ? 4'h0
                         : ext_cnt + 4'h1; // [RQ11]
         end
      end
   end

   always @* begin
      case (clock_select_reg[1:0])
         `PRE_DIV12: pre_tick = div12_tick; // [RQ10]
         `PRE_DIV4:  pre_tick = div4_tick;
         `PRE_DIV48: pre_tick = div48_tick;
         default:    pre_tick = ext8_tick;
      endcase
   end

   // ==========================================
   // Counting
   wire run0 = gate_ok(timer0_run_in, timer_mode_reg[`MODE_T0_QUALIFY],
                       in0_level, input0_polarity_in); // [RQ5]
   wire run1 = gate_ok(timer1_run_in, timer_mode_reg[`MODE_T1_QUALIFY],
                       in1_level, input1_polarity_in); // [RQ1] [RQ2]
   wire tick0 = clk_tick(timer_mode_reg[`MODE_T0_SOURCE],
                         clock_select_reg[`CKS_T0], cnt0_fall, pre_tick);
   wire tick1 = clk_tick(timer_mode_reg[`MODE_T1_SOURCE],
                         clock_select_reg[`CKS_T1], cnt1_fall, pre_tick);
   // Split high byte is a timer only, never a pin counter
   wire tick0h = clk_tick(1'b0, clock_select_reg[`CKS_T0], 1'b0,
                          pre_tick); // [RQ19]
   wire en0  = run0 & tick0;
   wire en1  = run1 & tick1 & (mode1 != `MODE_SPLIT); // [RQ4]
   wire en0h = timer1_run_in & tick0h; // [RQ19]
   // Timer 1 may not count pins or raise its flag while Timer 0 is split
   wire en1m = (mode0 == `MODE_SPLIT) ?
               (run1 & clk_tick(1'b0, clock_select_reg[`CKS_T1], 1'b0,
                pre_tick) & (mode1 != `MODE_SPLIT)) : en1;

   always @* begin
      next_t0_low  = timer0_low_byte;
      next_t0_high = timer0_high_byte;
      next_t1_low  = timer1_low_byte;
      next_t1_high = timer1_high_byte;
      next_ovf0    = 1'b0;
      next_ovf1    = 1'b0;
      if (en0) begin
         case (mode0) // [RQ7]
            `MODE_13BIT: begin
               next_t0_low = {timer0_low_byte[7:5],
                              timer0_low_byte[4:0] + 5'h01};
               if (timer0_low_byte[4:0] == 5'h1F) begin
                  next_t0_high = timer0_high_byte + 8'h01;
                  next_ovf0    = (timer0_high_byte == 8'hFF); // [RQ17]
               end
            end
            `MODE_16BIT: begin
               next_t0_low = timer0_low_byte + 8'h01;
               if (timer0_low_byte == 8'hFF) begin
                  next_t0_high = timer0_high_byte + 8'h01;
                  next_ovf0    = (timer0_high_byte == 8'hFF);
               end
            end
            `MODE_RELOAD: begin
               if (timer0_low_byte == 8'hFF) begin
                  next_t0_low = timer0_high_byte; // [RQ18]
                  next_ovf0   = 1'b1;
               end else
                  next_t0_low = timer0_low_byte + 8'h01;
            end
            default: begin
               next_t0_low = timer0_low_byte + 8'h01;
               next_ovf0   = (timer0_low_byte == 8'hFF);
            end
         endcase
      end
      if (mode0 == `MODE_SPLIT && en0h) begin
         next_t0_high = timer0_high_byte + 8'h01; // [RQ19]
         next_ovf1    = (timer0_high_byte == 8'hFF);
      end
      if (en1m) begin
         case (mode1) // [RQ4]
            `MODE_13BIT: begin
               next_t1_low = {timer1_low_byte[7:5],
                              timer1_low_byte[4:0] + 5'h01};
               if (timer1_low_byte[4:0] == 5'h1F) begin
                  next_t1_high = timer1_high_byte + 8'h01;
                  // Never mask a split high-byte overflow
                  next_ovf1    = next_ovf1 | ((mode0 != `MODE_SPLIT) &&
                                 (timer1_high_byte == 8'hFF)); // [RQ17]
               end
            end
            `MODE_16BIT: begin
               next_t1_low = timer1_low_byte + 8'h01;
               if (timer1_low_byte == 8'hFF) begin
                  next_t1_high = timer1_high_byte + 8'h01;
                  next_ovf1    = next_ovf1 | ((mode0 != `MODE_SPLIT) &&
                                 (timer1_high_byte == 8'hFF));
               end
            end
            `MODE_RELOAD: begin
               if (timer1_low_byte == 8'hFF) begin
                  next_t1_low = timer1_high_byte; // [RQ18]
                  next_ovf1   = next_ovf1 | (mode0 != `MODE_SPLIT);
               end else
                  next_t1_low = timer1_low_byte + 8'h01;
            end
            default: begin
               next_t1_low = timer1_low_byte;
            end
         endcase
      end
   end

   // ==========================================
   // Register writes and counter update
   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         timer_mode_reg      <= `RESET_BYTE;
         clock_select_reg    <= `RESET_BYTE;
         timer0_low_byte     <= `RESET_BYTE;
         timer0_high_byte    <= `RESET_BYTE;
         timer1_low_byte     <= `RESET_BYTE;
         timer1_high_byte    <= `RESET_BYTE;
         timer0_overflow_out <= 1'b0;
         timer1_overflow_out <= 1'b0;
      end else begin
         timer0_low_byte     <= next_t0_low;
         timer0_high_byte    <= next_t0_high;
         timer1_low_byte     <= next_t1_low;
         timer1_high_byte    <= next_t1_high;
         timer0_overflow_out <= next_ovf0;
         timer1_overflow_out <= next_ovf1;
         // Software write wins over a count in the same cycle
         if (reg_write_in) begin
            case (reg_addr_in)
               `ADDR_TIMER_MODE: timer_mode_reg <= reg_wdata_in;
               `ADDR_CLOCK_SELECT:
                  clock_select_reg <= reg_wdata_in
                                      & `CKS_WRITE_MASK; // [RQ14]
               `ADDR_T0_LOW:  timer0_low_byte  <= reg_wdata_in; // [RQ15]
               `ADDR_T0_HIGH: timer0_high_byte <= reg_wdata_in; // [RQ15]
               `ADDR_T1_LOW:  timer1_low_byte  <= reg_wdata_in; // [RQ16]
               `ADDR_T1_HIGH: timer1_high_byte <= reg_wdata_in; // [RQ20]
               default: ;
            endcase
         end
      end
   end

   // ==========================================
   // Read data
   always @(posedge ref_clk_in) begin
      if (!rst_b_in)
         reg_rdata_out <= 8'h00;
      else begin
         case (reg_addr_in)
            `ADDR_TIMER_MODE:   reg_rdata_out <= timer_mode_reg;
            `ADDR_CLOCK_SELECT: reg_rdata_out <= clock_select_reg; // [RQ14]
            `ADDR_T0_LOW:       reg_rdata_out <= timer0_low_byte; // [RQ15]
            `ADDR_T0_HIGH:      reg_rdata_out <= timer0_high_byte;
            `ADDR_T1_LOW:       reg_rdata_out <= timer1_low_byte; // [RQ16]
            `ADDR_T1_HIGH:      reg_rdata_out <= timer1_high_byte; // [RQ20]
            default:            reg_rdata_out <= 8'h00;
         endcase
      end
   end

   // ==========================================
   // Timer 2 clock enables
   always @* begin
      t2_ext_tick = timer2_ext_clk_select_in ? ext8_tick : div12_tick;
   end

   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         timer2_low_tick_out  <= 1'b0;
         timer2_high_tick_out <= 1'b0;
      end else begin
         timer2_low_tick_out <= clock_select_reg[`CKS_T2_LOW] ? 1'b1
                                : t2_ext_tick; // [RQ13]
         if (timer2_split_in)
            timer2_high_tick_out <= clock_select_reg[`CKS_T2_HIGH] ? 1'b1
                                    : t2_ext_tick; // [RQ12]
         else
            timer2_high_tick_out <= clock_select_reg[`CKS_T2_LOW] ? 1'b1
                                    : t2_ext_tick;
      end
   end
endmodule // dual_timer

// >>> hw/pin_edge_sync.v
// Three-stage pin synchroniser with a falling-edge and a rising-edge pulse.
// Assumes the pin is asynchronous to ref_clk_in.
`timescale 1ns/1ps
module pin_edge_sync (
   // Clock and reset
   input  wire ref_clk_in,
   input  wire rst_b_in,
   // Pin
   input  wire pin_in,
   // Synchronised results
   output reg  level_out,
   output reg  fall_out,
   output reg  rise_out
);
   reg sync_a;
   reg sync_b;
   reg sync_c;

   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         sync_a    <= 1'b1;
         sync_b    <= 1'b1;
         sync_c    <= 1'b1;
         level_out <= 1'b1;
         fall_out  <= 1'b0;
         rise_out  <= 1'b0;
      end else begin
         sync_a   <= pin_in;
         sync_b   <= sync_a;
         sync_c   <= sync_b;
         fall_out <= 1'b0;
         rise_out <= 1'b0;
         // Change counts once the two later stages agree
         if (sync_b == sync_c && sync_c != level_out) begin
            level_out <= sync_c;
            fall_out  <= ~sync_c;
            rise_out  <= sync_c;
         end
      end
   end
endmodule // pin_edge_sync

// >>> hw/timer_consts.vh
// Constants for the dual timer mode and clock select block.
// Assumes an 8-bit special-function-register port with 8-bit addresses.
`ifndef TIMER_CONSTS_VH
`define TIMER_CONSTS_VH

// ==========================================
// Register addresses
`define ADDR_TIMER_MODE   8'h89
`define ADDR_T0_LOW       8'h8A
`define ADDR_T1_LOW       8'h8B
`define ADDR_T0_HIGH      8'h8C
`define ADDR_T1_HIGH      8'h8D
`define ADDR_CLOCK_SELECT 8'h8E

// ==========================================
// Reset values
`define RESET_BYTE        8'h00

// ==========================================
// Mode register fields
`define MODE_T1_QUALIFY   7
`define MODE_T1_SOURCE    6
`define MODE_T1_HI        5
`define MODE_T1_LO        4
`define MODE_T0_QUALIFY   3
`define MODE_T0_SOURCE    2
`define MODE_T0_HI        1
`define MODE_T0_LO        0

// ==========================================
// Clock select register fields
`define CKS_T2_HIGH       6
`define CKS_T2_LOW        5
`define CKS_T1            4
`define CKS_T0            3
`define CKS_WRITE_MASK    8'h7B

// ==========================================
// Mode and prescale encodings
`define MODE_13BIT        2'b00
`define MODE_16BIT        2'b01
`define MODE_RELOAD       2'b10
`define MODE_SPLIT        2'b11
`define PRE_DIV12         2'b00
`define PRE_DIV4          2'b01
`define PRE_DIV48         2'b10
`define PRE_EXT8          2'b11

// ==========================================
// Divider figures
`define DIV_12            12
`define DIV_4             4
`define DIV_48            48
`define DIV_EXT           8

`endif

// >>> testbench/dual_timer_monitor.sv
// Port checker for the dual timer block.
// Assumes one clock domain and a synchronous active-low reset.
`timescale 1ns/1ps
module dual_timer_monitor (
   // Clock and reset
   input wire       ref_clk_in,
   input wire       rst_b_in,
   // Register port
   input wire [7:0] reg_addr_in,
   input wire [7:0] reg_wdata_in,
   input wire       reg_write_in,
   input wire [7:0] reg_rdata_out,
   // Controls and pins
   input wire       timer0_run_in,
   input wire       timer1_run_in,
   input wire       input1_polarity_in,
   input wire       timer2_split_in,
   input wire       ext_input1_in,
   // Events
   input wire       timer0_overflow_out,
   input wire       timer1_overflow_out,
   input wire       timer2_low_tick_out,
   input wire       timer2_high_tick_out
);
   default clocking cb @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);
   // ==========================================
   // Shadow copies of mode and clock select
   reg [7:0] mode_q;
   reg [7:0] cks_q;
   always @(posedge ref_clk_in) begin
      if (!rst_b_in) begin
         mode_q <= 8'h00;
         cks_q  <= 8'h00;
      end else if (reg_write_in && reg_addr_in == 8'h89) begin
         mode_q <= reg_wdata_in;
      end else if (reg_write_in && reg_addr_in == 8'h8E) begin
         cks_q  <= reg_wdata_in & 8'h7B;
      end
   end
   // ==========================================
   // Properties
   property p_unused_zero;
      $past(reg_addr_in) == 8'h8E |-> reg_rdata_out[7] == 1'b0
                                      && reg_rdata_out[2] == 1'b0;
   endproperty
   a_unused_zero: assert property (p_unused_zero)
      else $error("clock select unused bit reads one");
   property p_mode_rb;
      reg_write_in && reg_addr_in == 8'h89 ##1
      reg_addr_in == 8'h89 && !reg_write_in
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
   endproperty
   a_mode_rb: assert property (p_mode_rb)
      else $error("mode register readback wrong");
   property p_byte_rb;
      reg_write_in && reg_addr_in >= 8'h8A && reg_addr_in <= 8'h8D
      && !timer0_run_in && !timer1_run_in ##1
      reg_addr_in == $past(reg_addr_in) && !reg_write_in
      && !timer0_run_in && !timer1_run_in
      |=> reg_rdata_out == $past(reg_wdata_in, 2);
   endproperty
   a_byte_rb: assert property (p_byte_rb)
      else $error("count byte readback wrong");
   property p_t0_stop;
      (!timer0_run_in) [*6] |-> !timer0_overflow_out;
   endproperty
   a_t0_stop: assert property (p_t0_stop)
      else $error("timer 0 overflow while stopped");
   property p_t1_gate;
      (mode_q[7] && mode_q[1:0] != 2'b11
       && ext_input1_in != input1_polarity_in) [*8]
      |-> !timer1_overflow_out;
   endproperty
   a_t1_gate: assert property (p_t1_gate)
      else $error("timer 1 overflow with gate inactive");
   property p_t1_off;
      (mode_q[5:4] == 2'b11 && mode_q[1:0] != 2'b11) [*6]
      |-> !timer1_overflow_out;
   endproperty
   a_t1_off: assert property (p_t1_off)
      else $error("timer 1 overflow while inactive");
   property p_t2_low;
      cks_q[5] [*3] |-> timer2_low_tick_out;
   endproperty
   a_t2_low: assert property (p_t2_low)
      else $error("timer 2 low tick missing on system clock");
   property p_t2_high;
      (timer2_split_in && cks_q[6]) [*3] |-> timer2_high_tick_out;
   endproperty
   a_t2_high: assert property (p_t2_high)
      else $error("timer 2 high tick missing on system clock");
   property p_pin_once;
      mode_q[2] [*3] ##0 timer0_overflow_out |=> !timer0_overflow_out;
   endproperty
   a_pin_once: assert property (p_pin_once)
      else $error("pin counter overflowed twice in a row");
   c_split: cover property (mode_q[1:0] == 2'b11 && timer1_overflow_out);
   c_pin: cover property (mode_q[2] && timer0_overflow_out);
   c_high: cover property (timer2_split_in && timer2_high_tick_out);
endmodule // dual_timer_monitor

bind dual_timer dual_timer_monitor dual_timer_monitor_inst (
   .ref_clk_in, .rst_b_in, .reg_addr_in, .reg_wdata_in, .reg_write_in,
   .reg_rdata_out, .timer0_run_in, .timer1_run_in, .input1_polarity_in,
   .timer2_split_in, .ext_input1_in, .timer0_overflow_out,
   .timer1_overflow_out, .timer2_low_tick_out, .timer2_high_tick_out);

// >>> testbench/dual_timer_tb.sv
// Self-checking bench for the dual timer block with a pin model.
// Assumes the block's default divider parameters.
`timescale 1ns/1ps
module dual_timer_tb;
   logic       ref_clk_in, rst_b_in, wr_en, run0, run1, pol0, pol1;
   logic       split, xsel, cnt0, cnt1, timer0_input_qualify, timer1_input_qualify, eclk;
   logic       ovf0, ovf1, tick_lo, tick_hi;
   logic [7:0] addr, wdata, rdata, a, d, r;
   int         miscompares, samples_checked, cycles, n0, n1, nl, nh, p, i;
   logic [7:0] t2_cks [4] = '{8'h20, 8'h00, 8'h40, 8'h40};
   logic       t2_spl [4] = '{1'b0, 1'b0, 1'b1, 1'b0};
   int         t2_lo  [4] = '{480, 40, 40, 40};
   int         t2_hi  [4] = '{480, 40, 480, 40};

   dual_timer dual_timer_inst (
      .ref_clk_in(ref_clk_in), .rst_b_in(rst_b_in),
      .reg_addr_in(addr), .reg_wdata_in(wdata), .reg_write_in(wr_en),
      .reg_rdata_out(rdata), .timer0_run_in(run0), .timer1_run_in(run1),
      .input0_polarity_in(pol0), .input1_polarity_in(pol1),
      .timer2_split_in(split), .timer2_ext_clk_select_in(xsel),
      .ext_input0_in(timer0_input_qualify), .ext_input1_in(timer1_input_qualify),
      .timer0_count_pin_in(cnt0), .timer1_count_pin_in(cnt1),
      .ext_clk_in(eclk), .timer0_overflow_out(ovf0),
      .timer1_overflow_out(ovf1), .timer2_low_tick_out(tick_lo),
      .timer2_high_tick_out(tick_hi));
   pin_model pin_model_inst (
      .cnt0_out(cnt0), .cnt1_out(cnt1), .timer0_input_qualify_out(timer0_input_qualify),
      .timer1_input_qualify_out(timer1_input_qualify), .ext_clk_out(eclk));

   initial ref_clk_in = 1'b0;
   always #2.5 ref_clk_in = ~ref_clk_in;
   always @(posedge ref_clk_in) begin
      cycles++;
      if (cycles == 12000) begin
         miscompares++;
         complete_run;
      end
   end
   // ==========================================
   // Tasks
   task automatic step;
      @(posedge ref_clk_in);
      #1;
   endtask
   task automatic wr(input logic [7:0] wa, input logic [7:0] wd);
      addr  = wa;
      wdata = wd;
      wr_en = 1'b1;
      step;
      wr_en = 1'b0;
      step;
   endtask
   task automatic rd(input logic [7:0] ra, output logic [7:0] rv);
      addr = ra;
      step;
      rv = rdata;
   endtask
   task automatic chk_byte(input logic [7:0] got, input logic [7:0] exp);
      samples_checked++;
      if (got !== exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic chk_cnt(input int got, input int exp);
      samples_checked++;
      if (got != exp) begin
         miscompares++;
         $display("ERROR t=%0t got %h exp %h", $time, got, exp);
      end
   endtask
   task automatic count_win(input int n);
      n0 = 0;
      n1 = 0;
      nl = 0;
      nh = 0;
      repeat (n) begin
         step;
         n0 += (ovf0 === 1'b1);
         n1 += (ovf1 === 1'b1);
         nl += (tick_lo === 1'b1);
         nh += (tick_hi === 1'b1);
      end
   endtask
   task automatic load(input logic [7:0] v0, input logic [7:0] v1);
      wr(8'h8A, v0);
      wr(8'h8C, v0);
      wr(8'h8B, v1);
      wr(8'h8D, v1);
   endtask
   function automatic int pre_exp(input int sel, input int win);
      return win / (sel == 0 ? 12 : sel == 1 ? 4 : 48);
   endfunction
   task automatic complete_run;
      if (miscompares == 0 && samples_checked > 0)
         $display("[ PASS ]");
      else
         $display("[ FAIL ]");
      $finish;
   endtask
   // ==========================================
   // Main sequence
   initial begin
      {rst_b_in, wr_en, run0, run1, split, xsel} = 6'b00_0000;
      addr  = 8'h00;
      wdata = 8'h00;
      void'($urandom(49));
      pol0 = 1'($urandom);
      pol1 = 1'($urandom);
      repeat (10) step;
      rst_b_in = 1'b1;
      for (i = 0; i < 8; i++) begin
         rd(8'h88 + 8'(i), r);
         chk_byte(r, 8'h00);
      end
      repeat (24) begin
         a = 8'h89 + 8'($urandom % 6);
         d = 8'($urandom);
         wr(a, d);
         rd(a, r);
         chk_byte(r, a == 8'h8E ? d & 8'h7B : d);
      end
      wr(8'h8F, 8'hFF);
      rd(8'h8F, r);
      chk_byte(r, 8'h00);
      // Prescaler, reload every tick
      load(8'hFF, 8'hFF);
      wr(8'h89, 8'h22);
      for (p = 0; p < 4; p++) begin
         wr(8'h8E, 8'(p));
         pin_model_inst.ext_on = (p == 3);
         run0 = 1'b1;
         count_win(60);
         count_win(480);
         run0 = 1'b0;
         if (p == 3) chk_cnt(n0 >= 6 && n0 <= 8, 1);
         else chk_cnt(n0, pre_exp(p, 480));
      end
      pin_model_inst.ext_on = 1'b0;
      // System clock and gating
      pin_model_inst.set_gates(~pol0, ~pol1);
      wr(8'h8E, 8'h18);
      for (i = 0; i < 4; i++) begin
         wr(8'h89, i == 1 || i == 2 ? 8'hAA : i == 3 ? 8'h32 : 8'h22);
         if (i == 2) pin_model_inst.set_gates(pol0, pol1);
         run0 = 1'b1;
         run1 = 1'b1;
         count_win(10);
         count_win(50);
         chk_cnt(n0, i == 1 ? 0 : 50);
         chk_cnt(n1, i == 1 || i == 3 ? 0 : 50);
      end
      // Split mode upper byte
      run0 = 1'b0;
      run1 = 1'b0;
      wr(8'h8C, 8'hFF);
      wr(8'h89, 8'h13);
      run1 = 1'b1;
      count_win(300);
      chk_cnt(n1, 2);
      chk_cnt(n0, 0);
      // 13-bit and 16-bit wrap
      run1 = 1'b0;
      wr(8'h89, 8'h10);
      load(8'hFE, 8'hF0);
      wr(8'h8C, 8'hFF);
      wr(8'h8D, 8'hFF);
      run0 = 1'b1;
      run1 = 1'b1;
      count_win(40);
      chk_cnt(n0, 1);
      chk_cnt(n1, 1);
      run0 = 1'b0;
      run1 = 1'b0;
      rd(8'h8A, r);
      chk_byte(r & 8'hE0, 8'hE0);
      // Pin counting, clock select ignored
      wr(8'h89, 8'h66);
      load(8'hFE, 8'hFE);
      run0 = 1'b1;
      run1 = 1'b1;
      fork
         count_win(120);
         pin_model_inst.pulse(0, 6);
      join
      chk_cnt(n0, 3);
      chk_cnt(n1, 0);
      fork
         count_win(80);
         pin_model_inst.pulse(1, 4);
      join
      chk_cnt(n1, 2);
      // Timer 2 clock enables
      for (i = 0; i < 4; i++) begin
         wr(8'h8E, t2_cks[i]);
         split = t2_spl[i];
         count_win(20);
         count_win(480);
         chk_cnt(nl, t2_lo[i]);
         chk_cnt(nh, t2_hi[i]);
      end
      // Timer 2 external clock/8 path
      xsel = 1'b1;
      pin_model_inst.ext_on = 1'b1;
      wr(8'h8E, 8'h00);
      count_win(60);
      count_win(480);
      pin_model_inst.ext_on = 1'b0;
      chk_cnt(nl >= 6 && nl <= 8, 1);
      chk_cnt(nh >= 6 && nh <= 8, 1);
      complete_run;
   end
endmodule // dual_timer_tb

// >>> testbench/pin_model.sv
// Far-side model of count pins, gate inputs and external clock.
// Assumes its tasks are called just after a system clock edge.
`timescale 1ns/1ps
module pin_model (
   // Pins toward the timer block
   output logic cnt0_out,
   output logic cnt1_out,
   output logic timer0_input_qualify_out,
   output logic timer1_input_qualify_out,
   output logic ext_clk_out
);
   logic ext_on;
   initial begin
      cnt0_out    = 1'b1;
      cnt1_out    = 1'b1;
      timer0_input_qualify_out   = 1'b0;
      timer1_input_qualify_out   = 1'b0;
      ext_clk_out = 1'b0;
      ext_on      = 1'b0;
   end
   // Runs only on request, well below the system clock rate
   always #21 if (ext_on) ext_clk_out = ~ext_clk_out;
   task automatic pulse(input int which, input int n);
      repeat (n) begin
         if (which == 0) cnt0_out = 1'b0;
         else cnt1_out = 1'b0;
         #20;
         if (which == 0) cnt0_out = 1'b1;
         else cnt1_out = 1'b1;
         #20;
      end
   endtask
   task automatic set_gates(input logic g0, input logic g1);
      timer0_input_qualify_out = g0;
      timer1_input_qualify_out = g1;
   endtask
endmodule // pin_model
